/* File: src/core_ctl_regs.vh */
// Purpose: constants for the core status and cache configuration register bank
// Assumes: included by core_ctl_bank.v only
// Notes: bit positions, reset values and power-down codes
// Functional notes
// - upper sixteen status bits are read-only identification
// - power-down field bits 15:10 always read zero
// - codes 001001/010001 enter light sleep, interrupt wake
// - codes 011010/011100 enter deep sleeps, reset-only exit
// - clip flag set by unit, cleared by move
// - clip set beats same-cycle software clear
// - clip flag visible two cycles after saturation
// - false-condition instruction leaves clip flag alone
// - byte order bit 8 read-only, default little
// - program cache mode 7:5 takes 000 or 010
// - data cache mode 4:2 takes 000 or 010
// - interrupt taken copies global gate into saved gate
// - global gate bit 0 masks maskable interrupts
// - cache config bit 31 gives crossbar priority
// - cache config bit 9 invalidates program cache
// - cache config bit 8 invalidates data cache
// - way mode bits 2:0 take 000,001,010,011,111
// - reserved cache config bits read-only, writes ignored
`ifndef CORE_CTL_REGS_VH
`define CORE_CTL_REGS_VH
`define CSR_ID_HI 31
`define CSR_ID_LO 16
`define CSR_PWR_HI 15
`define CSR_PWR_LO 10
`define CSR_CLIP 9
`define CSR_ORDER 8
`define CSR_PCM_HI 7
`define CSR_PCM_LO 5
`define CSR_DCM_HI 4
`define CSR_DCM_LO 2
`define CSR_SAVED 1
`define CSR_GATE 0
`define CACHE_CONFIG_REG_PRIO 31
`define CACHE_CONFIG_REG_PFLUSH 9
`define CACHE_CONFIG_REG_DFLUSH 8
`define CACHE_CONFIG_REG_WAY_HI 2
`define CACHE_CONFIG_REG_WAY_LO 0
`define CACHE_MODE_RST 3'h0
`define CACHE_MODE_ALT 3'h2
`define WAY_MODE_RST 3'h0
`define WAY_NONE 3'h0
`define WAY_ONE 3'h1
`define WAY_TWO 3'h2
`define WAY_THREE 3'h3
`define WAY_FOUR 3'h7
`define ORDER_RST 1'h1
`define CACHE_CONFIG_REG_RSVH_HI 30
`define CACHE_CONFIG_REG_RSVH_LO 10
`define CACHE_CONFIG_REG_RSVL_HI 7
`define CACHE_CONFIG_REG_RSVL_LO 3
`define PWR_NONE 6'h00
`define PWR_LIGHT_EN 6'h09
`define PWR_LIGHT_ANY 6'h11
`define PWR_DEEP 6'h1a
`define PWR_DEEPEST 6'h1c
`define ST_RUN 2'h0
`define ST_LIGHT 2'h1
`define ST_DEEP 2'h2
`define ST_DEEPEST 2'h3
`endif

/* File: src/core_ctl_bank.v */
// Purpose: core control status and cache configuration registers
// Assumes: one clock, synchronous active-low reset, move-instruction access ports
// Notes: power-down state is reported, sequencing lives elsewhere
`timescale 1ns/10ps
`include "core_ctl_regs.vh"
module core_ctl_bank #(
  parameter [15:0] core_ident = 16'h00a5 // arbitrary value
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // endian strap
  input wire little_endian,
  // control move access
  input wire csr_wr,
  input wire [31:0] csr_wdata,
  output reg [31:0] csr_rdata,
  input wire cache_config_reg_wr,
  input wire [31:0] cache_config_reg_wdata,
  output reg [31:0] cache_config_reg_rdata,
  // functional unit and interrupt events
  input wire sat_event,
  input wire sat_cond_true,
  input wire irq_taken,
  input wire irq_pending,
  input wire irq_pending_enabled,
  // control outputs
  output reg irq_gate,
  output reg [1:0] sleep_state,
  output reg [2:0] program_cache_mode,
  output reg [2:0] data_cache_mode,
  output reg l2_arbitration_bit,
  output reg program_cache_flush,
  output reg data_cache_flush,
  output reg [2:0] l2_way_mode
);

  // ******************************
  // legal field codes
  // ******************************
  function cache_ok;
    input [2:0] code;
    begin
      cache_ok = (code == `CACHE_MODE_RST) || (code == `CACHE_MODE_ALT);
    end
  endfunction

  function way_ok;
    input [2:0] code;
    begin
      way_ok = (code == `WAY_NONE) || (code == `WAY_ONE) || (code == `WAY_TWO) || (code == `WAY_THREE)
               || (code == `WAY_FOUR);
    end
  endfunction

  // ******************************
  // power-down state codes
  // ******************************
  localparam [1:0] st_run = `ST_RUN;
  localparam [1:0] st_light = `ST_LIGHT;
  localparam [1:0] st_deep = `ST_DEEP;
  localparam [1:0] st_deepest = `ST_DEEPEST;

  // maps a written power-down code to the state it asks for; reserved codes keep running
  function [1:0] sleep_target;
    input [5:0] code;
    begin
      case (code)
        `PWR_LIGHT_EN: sleep_target = st_light;
        `PWR_LIGHT_ANY: sleep_target = st_light;
        `PWR_DEEP: sleep_target = st_deep;
        `PWR_DEEPEST: sleep_target = st_deepest;
        default: sleep_target = st_run;
      endcase
    end
  endfunction

  reg clip_flag;
  reg clip_pend;
  reg saved_gate;
  reg order_bit;
  reg wake_any;
  reg [1:0] next_sleep;
  wire [5:0] pwr_code;
  wire run_write;

  assign pwr_code = csr_wdata[`CSR_PWR_HI:`CSR_PWR_LO];
  // a power-down code is only acted on while the core runs
  assign run_write = csr_wr && (sleep_state == st_run);

  // ******************************
  // power-down states
  // ******************************
  always @* begin
    next_sleep = sleep_state;
    case (sleep_state)
      st_run: begin
        if (csr_wr) begin
          next_sleep = sleep_target(pwr_code);
        end
      end
      st_light: begin
        if (wake_any ? irq_pending : irq_pending_enabled) begin
          next_sleep = st_run;
        end
      end
      st_deep: begin
        next_sleep = st_deep;
      end
      st_deepest: begin
        next_sleep = st_deepest;
      end
      default: begin
        next_sleep = st_run;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      sleep_state <= st_run;
      wake_any <= 1'b0;
    end else begin
      sleep_state <= next_sleep;
      // the light-sleep code written picks the wake source
      if (run_write && pwr_code == `PWR_LIGHT_ANY) begin
        wake_any <= 1'b1;
      end else if (run_write && pwr_code == `PWR_LIGHT_EN) begin
        wake_any <= 1'b0;
      end
    end
  end

  // ******************************
  // saturation flag
  // ******************************
  // the pending stage is the one-cycle delay slot before the flag shows
  always @(posedge clk) begin
    if (!resetn) begin
      clip_pend <= 1'b0;
      clip_flag <= 1'b0;
    end else begin
      clip_pend <= sat_event && sat_cond_true;
      if (clip_pend) begin
        clip_flag <= 1'b1;
      end else if (csr_wr && !csr_wdata[`CSR_CLIP]) begin
        clip_flag <= 1'b0;
      end
    end
  end

  // ******************************
  // interrupt gates
  // ******************************
  // a taken interrupt outranks a move in the same cycle so the saved copy is never lost
  always @(posedge clk) begin
    if (!resetn) begin
      saved_gate <= 1'b0;
      irq_gate <= 1'b0;
    end else if (irq_taken) begin
      saved_gate <= irq_gate;
      irq_gate <= 1'b0;
    end else if (csr_wr) begin
      saved_gate <= csr_wdata[`CSR_SAVED];
      irq_gate <= csr_wdata[`CSR_GATE];
    end
  end

  // ******************************
  // cache modes and endian strap
  // ******************************
  always @(posedge clk) begin
    if (!resetn) begin
      program_cache_mode <= `CACHE_MODE_RST;
      data_cache_mode <= `CACHE_MODE_RST;
      order_bit <= `ORDER_RST;
    end else begin
      order_bit <= little_endian;
      if (csr_wr && cache_ok(csr_wdata[`CSR_PCM_HI:`CSR_PCM_LO])) begin
        program_cache_mode <= csr_wdata[`CSR_PCM_HI:`CSR_PCM_LO];
      end
      if (csr_wr && cache_ok(csr_wdata[`CSR_DCM_HI:`CSR_DCM_LO])) begin
        data_cache_mode <= csr_wdata[`CSR_DCM_HI:`CSR_DCM_LO];
      end
    end
  end

  // ******************************
  // cache configuration register
  // ******************************
  always @(posedge clk) begin
    if (!resetn) begin
      l2_arbitration_bit <= 1'b0;
      program_cache_flush <= 1'b0;
      data_cache_flush <= 1'b0;
      l2_way_mode <= `WAY_MODE_RST;
    end else begin
      program_cache_flush <= cache_config_reg_wr && cache_config_reg_wdata[`CACHE_CONFIG_REG_PFLUSH];
      data_cache_flush <= cache_config_reg_wr && cache_config_reg_wdata[`CACHE_CONFIG_REG_DFLUSH];
      if (cache_config_reg_wr) begin
        l2_arbitration_bit <= cache_config_reg_wdata[`CACHE_CONFIG_REG_PRIO];
        if (way_ok(cache_config_reg_wdata[`CACHE_CONFIG_REG_WAY_HI:`CACHE_CONFIG_REG_WAY_LO])) begin
          l2_way_mode <= cache_config_reg_wdata[`CACHE_CONFIG_REG_WAY_HI:`CACHE_CONFIG_REG_WAY_LO];
        end
      end
    end
  end

  // ******************************
  // read data
  // ******************************
  // read-only and always-zero fields are built here, so write data never reaches them
  wire [31:0] csr_image;
  wire [31:0] cache_config_reg_image;

  assign csr_image[`CSR_ID_HI:`CSR_ID_LO] = core_ident;
  assign csr_image[`CSR_PWR_HI:`CSR_PWR_LO] = `PWR_NONE;
  assign csr_image[`CSR_CLIP] = clip_flag;
  assign csr_image[`CSR_ORDER] = order_bit;
  assign csr_image[`CSR_PCM_HI:`CSR_PCM_LO] = program_cache_mode;
  assign csr_image[`CSR_DCM_HI:`CSR_DCM_LO] = data_cache_mode;
  assign csr_image[`CSR_SAVED] = saved_gate;
  assign csr_image[`CSR_GATE] = irq_gate;
  assign cache_config_reg_image[`CACHE_CONFIG_REG_PRIO] = l2_arbitration_bit;
  assign cache_config_reg_image[`CACHE_CONFIG_REG_RSVH_HI:`CACHE_CONFIG_REG_RSVH_LO] = 21'h00_0000;
  // invalidate strobes are write-only and read back as zero
  assign cache_config_reg_image[`CACHE_CONFIG_REG_PFLUSH] = 1'h0;
  assign cache_config_reg_image[`CACHE_CONFIG_REG_DFLUSH] = 1'h0;
  assign cache_config_reg_image[`CACHE_CONFIG_REG_RSVL_HI:`CACHE_CONFIG_REG_RSVL_LO] = 5'h00;
  assign cache_config_reg_image[`CACHE_CONFIG_REG_WAY_HI:`CACHE_CONFIG_REG_WAY_LO] = l2_way_mode;

  always @(posedge clk) begin
    if (!resetn) begin
      csr_rdata <= 32'h0000_0000;
      cache_config_reg_rdata <= 32'h0000_0000;
    end else begin
      csr_rdata <= csr_image;
      cache_config_reg_rdata <= cache_config_reg_image;
    end
  end

endmodule // core_ctl_bank

/* File: testbench/core_ctl_checker.sv */
// Purpose: port checks of the core control register bank
// Assumes: bound to core_ctl_bank, readback lags fields by one edge
// Notes: clip flag has one extra delay slot
`timescale 1ns/10ps
module core_ctl_checker #(
  parameter [15:0] core_ident = 16'h00a5 // arbitrary value
) (
  // clock, reset and requests
  input logic clk, resetn, little_endian, csr_wr, cache_config_reg_wr, sat_event, sat_cond_true, irq_taken,
  input logic [31:0] csr_wdata, csr_rdata, cache_config_reg_wdata,
  // field outputs
  input logic irq_gate, program_cache_flush, data_cache_flush,
  input logic [1:0] sleep_state,
  input logic [2:0] program_cache_mode, l2_way_mode
);
  // ********
  // assertions
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  id_power_read_a: assert property ($past(resetn, 2) |-> csr_rdata[31:10] == {core_ident, 6'h00})
    else $error("status id or power field wrong");
  byte_order_a: assert property ($past(resetn, 2) |-> csr_rdata[8] == $past(little_endian, 2))
    else $error("byte order bit wrong");
  gate_write_a: assert property (csr_wr && !irq_taken |=> irq_gate == $past(csr_wdata[0]))
    else $error("global gate not written");
  saved_gate_a: assert property (irq_taken && !csr_wr ##1 !csr_wr && !irq_taken
    |=> csr_rdata[1] == $past(irq_gate, 2) && !irq_gate) else $error("saved gate wrong");
  clip_set_a: assert property (sat_event && sat_cond_true |-> ##3 csr_rdata[9])
    else $error("clip flag not set");
  clip_cause_a: assert property ($rose(csr_rdata[9]) |-> $past(sat_event && sat_cond_true, 3))
    else $error("clip flag set without cause");
  cache_mode_a: assert property (csr_wr && csr_wdata[7:5] inside {0, 2}
    |=> program_cache_mode == $past(csr_wdata[7:5])) else $error("program cache mode wrong");
  way_mode_a: assert property (cache_config_reg_wr && cache_config_reg_wdata[2:0] inside {[0:3], 7}
    |=> l2_way_mode == $past(cache_config_reg_wdata[2:0])) else $error("way mode wrong");
  flush_pulse_a: assert property ({program_cache_flush, data_cache_flush}
    == $past({2{cache_config_reg_wr}} & cache_config_reg_wdata[9:8])) else $error("flush pulse wrong");
  deep_hold_a: assert property (sleep_state[1] |=> sleep_state == $past(sleep_state))
    else $error("deep sleep left");
  cover property (sat_event && sat_cond_true && csr_wr);
  cover property (irq_taken);
  cover property (sleep_state == 2'h3);
  cover property (sat_event && sat_cond_true ##1 csr_wr && !csr_wdata[9]);
endmodule // core_ctl_checker

/* File: testbench/cpu_status_and_cache_config_regs_test.sv */
// Purpose: random and corner tests of the core control register bank
// Assumes: default identity value
// Notes: a shadow model predicts both readbacks
`timescale 1ns/10ps
module cpu_status_and_cache_config_regs_test;
  logic clk = 0, resetn = 0, little_endian = 1, csr_wr = 0, cache_config_reg_wr = 0, sat_event = 0, sat_cond_true = 0;
  logic irq_taken = 0, irq_pending = 0, irq_pending_enabled = 0, gate, saved, clip, prio;
  logic [31:0] csr_wdata = 0, cache_config_reg_wdata = 0, d;
  logic [2:0] pcm, dcm, way;
  logic [5:0] codes [4] = '{6'h09, 6'h11, 6'h1a, 6'h1c};
  logic [1:0] states [4] = '{1, 1, 2, 3};
  wire [31:0] csr_rdata, cache_config_reg_rdata;
  wire irq_gate, l2_arbitration_bit, program_cache_flush, data_cache_flush;
  wire [1:0] sleep_state;
  wire [2:0] program_cache_mode, data_cache_mode, l2_way_mode;
  int error_cnt = 0, compares = 0;
  integer seed = 57520;
  core_ctl_bank dut (.clk(clk), .resetn(resetn), .little_endian(little_endian), .csr_wr(csr_wr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .cache_config_reg_wr(cache_config_reg_wr), .cache_config_reg_wdata(cache_config_reg_wdata),
    .cache_config_reg_rdata(cache_config_reg_rdata), .sat_event(sat_event), .sat_cond_true(sat_cond_true), .irq_taken(irq_taken),
    .irq_pending(irq_pending), .irq_pending_enabled(irq_pending_enabled), .irq_gate(irq_gate),
    .sleep_state(sleep_state), .program_cache_mode(program_cache_mode), .data_cache_mode(data_cache_mode),
    .l2_arbitration_bit(l2_arbitration_bit), .program_cache_flush(program_cache_flush),
    .data_cache_flush(data_cache_flush), .l2_way_mode(l2_way_mode));
  always #5 clk = ~clk;
  // ********
  // tasks
  // ********
  task tick; @(posedge clk); #1; endtask
  task idle(input int n); csr_wr = 0; cache_config_reg_wr = 0; sat_event = 0; irq_taken = 0; repeat (n) tick; endtask
  task check(input [31:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin error_cnt++; $display("ERROR %s expected %h seen %h", what, exp, seen); end
  endtask
  function [31:0] csr_exp; csr_exp = {16'h00a5, 6'h00, clip, little_endian, pcm, dcm, saved, gate}; endfunction
  function [2:0] keep(input [2:0] n, o, input ok); keep = ok ? n : o; endfunction
  task rst; resetn = 0; idle(8); resetn = 1; {gate, saved, clip, prio, pcm, dcm, way} = 0; tick; endtask
  task results;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin #100000; error_cnt++; results; end
  initial begin
    rst; idle(2);
    check(csr_rdata, csr_exp(), "status reset");
    check(cache_config_reg_rdata & 32'h8000_00ff, 0, "cache reset");
    sat_event = 1; sat_cond_true = 1; tick; sat_event = 0; csr_wr = 1; csr_wdata = 32'h0000_8000; tick; idle(2);
    clip = 1;
    check(csr_rdata, csr_exp(), "clip set wins");
    $display("reset test done");
    repeat (40) begin
      d = $random(seed); d[15] = 1; little_endian = d[16]; sat_event = d[17]; sat_cond_true = d[18];
      csr_wr = 1; csr_wdata = d; tick; idle(2);
      clip = clip & d[9] | d[17] & d[18]; gate = d[0]; saved = d[1];
      pcm = keep(d[7:5], pcm, d[7:5] inside {0, 2}); dcm = keep(d[4:2], dcm, d[4:2] inside {0, 2});
      check(csr_rdata, csr_exp(), "status");
      check(data_cache_mode, dcm, "data mode");
      check(sleep_state, 0, "reserved power code");
      irq_taken = 1; saved = gate; gate = 0; tick; idle(2);
      check(csr_rdata, csr_exp(), "irq saved");
      d = $random(seed); cache_config_reg_wr = 1; cache_config_reg_wdata = d; tick;
      check({program_cache_flush, data_cache_flush}, d[9:8], "flush");
      idle(2); prio = d[31]; way = keep(d[2:0], way, d[2:0] inside {[0:3], 7});
      check(cache_config_reg_rdata & 32'h8000_00ff, {prio, 28'h0, way}, "cache cfg");
      check(l2_arbitration_bit, prio, "priority");
    end
    $display("register test done");
    foreach (codes[i]) begin
      rst; csr_wr = 1; csr_wdata = {16'h0, codes[i], 10'h0}; tick; idle(2);
      check(sleep_state, states[i], "sleep");
      irq_pending = 1; idle(3);
      check(sleep_state, i == 1 ? 0 : states[i], "any wake");
      irq_pending_enabled = 1; idle(3); {irq_pending, irq_pending_enabled} = 0;
      check(sleep_state, i < 2 ? 0 : states[i], "enabled wake");
    end
    $display("sleep test done");
    results;
  end
endmodule // cpu_status_and_cache_config_regs_test
bind core_ctl_bank core_ctl_checker #(.core_ident(core_ident)) chk (.clk(clk), .resetn(resetn),
  .little_endian(little_endian), .csr_wr(csr_wr), .cache_config_reg_wr(cache_config_reg_wr), .sat_event(sat_event),
  .sat_cond_true(sat_cond_true), .irq_taken(irq_taken), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
  .cache_config_reg_wdata(cache_config_reg_wdata), .irq_gate(irq_gate), .program_cache_flush(program_cache_flush),
  .data_cache_flush(data_cache_flush), .sleep_state(sleep_state), .program_cache_mode(program_cache_mode),
  .l2_way_mode(l2_way_mode));
